// ---- core/byte_buffer.v ----
/*
   Frame buffer of 256 bytes with one write port and one registered
   read port.
   Assumes one clock; contents are undefined after reset.
*/
`timescale 1ns/1ps
`include "frame_xfer_defines.vh"

module byte_buffer (
   input  wire               clk_i,
   input  wire               rst_n_i,
   input  wire               wr_en_i,
   input  wire [`BUF_AW-1:0] wr_addr_i,
   input  wire [7:0]         wr_data_i,
   input  wire [`BUF_AW-1:0] rd_addr_i,
   output reg  [7:0]         rd_data_o
);

   reg [7:0] mem [0:(1<<`BUF_AW)-1];

   // Write port
   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // Read port, one cycle latency
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= mem[rd_addr_i];
      end
   end

endmodule // byte_buffer

// ---- core/frame_xfer.v ----
/*
   Host-program frame transfer in both directions in 8-byte words.
   Host frames fill a one-frame receive buffer;
   a send buffer filled via a FIFO drains to the
   host subframe by subframe.
   Assumes one request outstanding and inputs
   synchronous to core_clk_i.
*/
// Notes on behaviour
// - Each subframe: two coordination bytes then six payload bytes.
// - Module answers request-to-send with acknowledgement 5001.
// - Last subframe may carry fewer than six valid bytes; accepted.
// - Every subframe acknowledged, payload appended until frame complete.
// - Complete frame is joined and offered to the internal program.
// - A 256-byte send buffer holds data waiting for the host.
// - Data goes to host only after program filled and started send.
// - Receive buffer holds one frame; no new frame until emptied.
// - On A080 the module sends six bytes plus subframe number, in order.
// - Termination 5000; second word 00XX when valid, FFXX on error.
`timescale 1ns/1ps
`include "frame_xfer_defines.vh"

module frame_xfer (
   input  wire        core_clk_i,
   input  wire        rst_n_i,
   input  wire        host_word_valid_i,
   input  wire [63:0] host_word_i,
   output reg         host_ready_o,
   output reg         ans_valid_o,
   output reg  [63:0] ans_word_o,
   output reg         rx_frame_ready_o,
   output reg  [8:0]  rx_len_o,
   input  wire [7:0]  rx_rd_addr_i,
   output wire [7:0]  rx_rd_data_o,
   input  wire        rx_release_i,
   input  wire [7:0]  tx_byte_i,
   input  wire        tx_valid_i,
   output wire        tx_ready_o,
   input  wire        tx_start_i,
   output reg         tx_busy_o
);

   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_STORE = 3'b010;
   localparam [2:0] ST_LOAD  = 3'b100;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   reg         rst_q1;
   reg         rst_q2;
   wire        rst_n;
   reg  [2:0]  state;
   reg  [2:0]  idx;
   reg  [2:0]  nvalid;
   reg  [47:0] payload;
   reg  [7:0]  cur_nr;
   reg         rx_busy;
   reg  [8:0]  rx_cnt;
   reg  [7:0]  rx_seq;
   reg  [8:0]  tx_len;
   reg  [8:0]  tx_cnt;
   reg  [8:0]  tx_sent;
   reg  [2:0]  tx_seg;
   reg  [7:0]  tx_seq;
   wire [7:0]  req_code;
   wire [7:0]  req_sub;
   wire [15:0] req_len;
   wire        req_take;
   wire [8:0]  rx_left;
   wire [2:0]  rx_part;
   wire [8:0]  rx_total;
   wire [8:0]  tx_next_sent;
   wire [8:0]  tx_left_now;
   wire [8:0]  tx_left_next;
   wire [7:0]  tx_rd_data;
   wire [7:0]  tx_fill_byte;
   wire        fifo_valid;
   wire        fifo_ready;
   wire [7:0]  fifo_data;
   wire        rx_wr_en;
   wire [7:0]  rx_wr_addr;
   wire [7:0]  tx_rd_addr;
   wire [7:0]  load_byte;

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end

   assign rst_n = rst_q2;

   ////////////////////////////////////////////////////////////////////////
   // Request decode and length arithmetic
   assign req_code = host_word_i[63:56];
   assign req_sub  = host_word_i[55:48];
   assign req_len  = host_word_i[47:32];
   assign req_take = host_word_valid_i & host_ready_o;

   // Bytes of this subframe that belong to the frame
   assign rx_left  = rx_len_o - rx_cnt;
   assign rx_part  = (rx_left > {6'h00, `SUB_PAYLOAD}) ? `SUB_PAYLOAD :
                     rx_left[2:0];
   assign rx_total = rx_cnt + {6'h00, nvalid};

   // Send-side progress once the host acknowledges the current subframe
   assign tx_next_sent = tx_sent + {6'h00, tx_seg};
   assign tx_left_now  = tx_len;
   assign tx_left_next = tx_len - tx_next_sent;

   ////////////////////////////////////////////////////////////////////////
   // Buffer ports
   assign rx_wr_en     = (state == ST_STORE) && (idx < nvalid);
   assign rx_wr_addr   = rx_cnt[7:0] + {5'h00, idx};
   assign tx_rd_addr   = tx_sent[7:0] + {5'h00, idx};
   // Unused tail bytes of a short subframe go out as zero
   assign load_byte    = ((idx - 3'h1) < nvalid) ? tx_rd_data : 8'h00;
   assign tx_fill_byte = fifo_data;
   // Drain stalls while sending, while starting, or when buffer is full
   assign fifo_ready   = ~tx_busy_o & ~tx_start_i &
                         (tx_cnt != `BUF_BYTES);

   ////////////////////////////////////////////////////////////////////////
   // Program data path into the send buffer
   stream_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_tx_fifo (
      .clk_i       (core_clk_i),
      .rst_n_i     (rst_n),
      .in_data_i   (tx_byte_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_ready)
   );

   // Send buffer of one frame
   byte_buffer u_tx_buf (
      .clk_i     (core_clk_i),
      .rst_n_i   (rst_n),
      .wr_en_i   (fifo_valid & fifo_ready),
      .wr_addr_i (tx_cnt[7:0]),
      .wr_data_i (tx_fill_byte),
      .rd_addr_i (tx_rd_addr),
      .rd_data_o (tx_rd_data)
   );

   // Receive buffer of one frame, read by the program
   byte_buffer u_rx_buf (
      .clk_i     (core_clk_i),
      .rst_n_i   (rst_n),
      .wr_en_i   (rx_wr_en),
      .wr_addr_i (rx_wr_addr),
      .wr_data_i (payload[47:40]),
      .rd_addr_i (rx_rd_addr_i),
      .rd_data_o (rx_rd_data_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Send buffer fill count and send start
   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt <= `CNT_RESET;
         tx_len <= `CNT_RESET;
      end else begin
         if (fifo_valid & fifo_ready) begin
            tx_cnt <= tx_cnt + 9'h001;
         end
         if (tx_start_i && !tx_busy_o && (tx_cnt != `CNT_RESET)) begin
            tx_len <= tx_cnt;
         end
         if ((state == ST_IDLE) && req_take && (req_code == `REQ_ACK) &&
             tx_busy_o && (req_sub == tx_seq) &&
             (tx_next_sent == tx_len)) begin
            tx_cnt <= `CNT_RESET;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequencer: requests, subframe store and subframe load
   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state            <= ST_IDLE;
         host_ready_o     <= 1'b0;
         ans_valid_o      <= 1'b0;
         ans_word_o       <= 64'h0000000000000000;
         rx_frame_ready_o <= 1'b0;
         rx_len_o         <= `CNT_RESET;
         tx_busy_o        <= 1'b0;
         idx              <= 3'h0;
         nvalid           <= 3'h0;
         payload          <= 48'h000000000000;
         cur_nr           <= `SEQ_RESET;
         rx_busy          <= 1'b0;
         rx_cnt           <= `CNT_RESET;
         rx_seq           <= `SEQ_RESET;
         tx_sent          <= `CNT_RESET;
         tx_seg           <= 3'h0;
         tx_seq           <= `SEQ_RESET;
      end else begin
         ans_valid_o <= 1'b0;
         // Program empties the receive buffer
         if (rx_release_i) begin
            rx_frame_ready_o <= 1'b0;
         end
         if (tx_start_i && !tx_busy_o && (tx_cnt != `CNT_RESET)) begin
            tx_busy_o <= 1'b1;
            tx_sent   <= `CNT_RESET;
         end
         case (state)
            ST_IDLE: begin
               host_ready_o <= 1'b1;
               if (req_take) begin
                  ans_valid_o <= 1'b1;
                  ans_word_o  <= {`ANS_INFO, `ANS_LAST, `ANS_ERR,
                                  `ANS_NONE, `ANS_PAD, `ANS_NONE};
                  case (req_code)
                     `REQ_COORD: begin
                        if (req_sub == `COORD_SEND) begin
                           if (rx_busy || rx_frame_ready_o ||
                               (req_len == 16'h0000) ||
                               (req_len > {7'h00, `BUF_BYTES})) begin
                              ans_word_o <= {`ANS_INFO, `ANS_MORE,
                                             `ANS_ERR, `ANS_NONE,
                                             `ANS_PAD, `ANS_NONE};
                           end else begin
                              ans_word_o <= {`ANS_INFO, `ANS_MORE,
                                             `ANS_OK, `ANS_NONE,
                                             `ANS_PAD, `ANS_NONE};
                              rx_busy    <= 1'b1;
                              rx_len_o   <= req_len[8:0];
                              rx_cnt     <= `CNT_RESET;
                              rx_seq     <= `SEQ_FIRST;
                           end
                        end else if ((req_sub == `COORD_RECV) &&
                                     tx_busy_o) begin
                           // Start or restart delivery from the first byte
                           ans_valid_o  <= 1'b0;
                           ans_word_o   <= ans_word_o;
                           host_ready_o <= 1'b0;
                           tx_sent      <= `CNT_RESET;
                           tx_seq       <= `SEQ_FIRST;
                           nvalid       <= (tx_left_now >
                                           {6'h00, `SUB_PAYLOAD}) ?
                                           `SUB_PAYLOAD : tx_left_now[2:0];
                           idx          <= 3'h0;
                           state        <= ST_LOAD;
                        end
                     end
                     `REQ_DATA: begin
                        if (rx_busy && (req_sub == rx_seq)) begin
                           ans_valid_o  <= 1'b0;
                           ans_word_o   <= ans_word_o;
                           host_ready_o <= 1'b0;
                           payload      <= host_word_i[47:0];
                           nvalid       <= rx_part;
                           cur_nr       <= req_sub;
                           idx          <= 3'h0;
                           state        <= ST_STORE;
                        end else begin
                           ans_word_o <= {`ANS_INFO, `ANS_MORE, `ANS_ERR,
                                          req_sub, `ANS_PAD,
                                          `ANS_NONE};
                        end
                     end
                     `REQ_ACK: begin
                        if (tx_busy_o && (req_sub == tx_seq)) begin
                           if (tx_next_sent == tx_len) begin
                              ans_word_o <= {`ANS_INFO, `ANS_LAST,
                                             `ANS_OK, req_sub,
                                             `ANS_PAD, `ANS_NONE};
                              tx_busy_o  <= 1'b0;
                              tx_sent    <= `CNT_RESET;
                           end else begin
                              ans_valid_o  <= 1'b0;
                              ans_word_o   <= ans_word_o;
                              host_ready_o <= 1'b0;
                              tx_sent      <= tx_next_sent;
                              tx_seq       <= tx_seq + 8'h01;
                              nvalid       <= (tx_left_next >
                                             {6'h00, `SUB_PAYLOAD}) ?
                                             `SUB_PAYLOAD :
                                             tx_left_next[2:0];
                              idx          <= 3'h0;
                              state        <= ST_LOAD;
                           end
                        end else begin
                           ans_word_o <= {`ANS_INFO, `ANS_LAST, `ANS_ERR,
                                          req_sub, `ANS_PAD, `ANS_NONE};
                        end
                     end
                     default: ans_valid_o <= 1'b1;
                  endcase
               end
            end
            ST_STORE: begin
               // One payload byte per cycle into the receive buffer
               host_ready_o <= 1'b0;
               idx          <= idx + 3'h1;
               payload      <= {payload[39:0], 8'h00};
               if (idx == 3'h5) begin
                  rx_cnt       <= rx_total;
                  rx_seq       <= rx_seq + 8'h01;
                  ans_valid_o  <= 1'b1;
                  host_ready_o <= 1'b1;
                  state        <= ST_IDLE;
                  if (rx_total == rx_len_o) begin
                     rx_busy          <= 1'b0;
                     rx_frame_ready_o <= 1'b1;
                     ans_word_o <= {`ANS_INFO, `ANS_LAST, `ANS_OK, cur_nr,
                                    `ANS_PAD, `ANS_NONE};
                  end else begin
                     ans_word_o <= {`ANS_INFO, `ANS_MORE, `ANS_OK, cur_nr,
                                    `ANS_PAD, `ANS_NONE};
                  end
               end
            end
            ST_LOAD: begin
               // Address leads data by one cycle; bytes leave in order
               host_ready_o <= 1'b0;
               idx          <= idx + 3'h1;
               if (idx != 3'h0) begin
                  payload <= {payload[39:0], load_byte};
               end
               if (idx == 3'h6) begin
                  tx_seg       <= nvalid;
                  ans_valid_o  <= 1'b1;
                  host_ready_o <= 1'b1;
                  ans_word_o   <= {`REQ_DATA, tx_seq, payload[39:0],
                                   load_byte};
                  state        <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule // frame_xfer

// ---- core/stream_fifo.v ----
/*
   Synchronous valid/ready FIFO, width and depth as parameters;
   input ready is registered.
   Assumes one clock and a synchronised active-low reset.
*/
`timescale 1ns/1ps

module stream_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output reg              in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);

   localparam [AW:0] FULL_COUNT = DEPTH;

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr;
   reg  [AW-1:0]    rd_ptr;
   reg  [AW:0]      count;
   reg  [AW:0]      next_count;
   wire             push;
   wire             pop;

   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];

   // Occupancy after this cycle
   always @* begin
      next_count = count;
      if (push & ~pop) begin
         next_count = count + 1'b1;
      end else if (pop & ~push) begin
         next_count = count - 1'b1;
      end
   end

   // Storage, no reset needed
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and registered full flag
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr     <= {AW{1'b0}};
         rd_ptr     <= {AW{1'b0}};
         count      <= {(AW+1){1'b0}};
         in_ready_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count      <= next_count;
         in_ready_o <= (next_count != FULL_COUNT);
      end
   end

endmodule // stream_fifo

// ---- shared/frame_xfer_defines.vh ----
/*
   Codes, sizes and reset values of the frame-transfer block.
   Assumes inclusion by bare name.
*/
`ifndef FRAME_XFER_DEFINES_VH
`define FRAME_XFER_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// Byte 0 of a host request word
`define REQ_COORD      8'hA0
`define REQ_DATA       8'hB0
`define REQ_ACK        8'hC0

// Byte 1 of a coordination request
`define COORD_SEND     8'h01
`define COORD_RECV     8'h80

////////////////////////////////////////////////////////////////////////////
// Answer word fields
`define ANS_INFO       8'h50
`define ANS_MORE       8'h01
`define ANS_LAST       8'h00
`define ANS_OK         8'h00
`define ANS_ERR        8'hFF
`define ANS_NONE       8'h00
`define ANS_PAD        24'h000000

// Sizes
`define BUF_BYTES      9'h100
`define BUF_AW         8
`define SUB_PAYLOAD    3'h6
`define FIFO_WIDTH     8
`define FIFO_DEPTH     16
`define FIFO_AW        4

// Start and reset values
`define SEQ_FIRST      8'h01
`define SEQ_RESET      8'h00
`define CNT_RESET      9'h000

`endif

// ---- sim/frame_xfer_asserts.sv ----
/*
   Port assertions and covers for frame_xfer.
   Assumes raw active-low reset and core_clk_i.
*/
`timescale 1ns/1ps

module frame_xfer_asserts (
   input wire        core_clk_i,
   input wire        rst_n_i,
   input wire        host_word_valid_i,
   input wire [63:0] host_word_i,
   input wire        host_ready_o,
   input wire        ans_valid_o,
   input wire [63:0] ans_word_o,
   input wire        rx_frame_ready_o,
   input wire [8:0]  rx_len_o,
   input wire        rx_release_i,
   input wire        tx_start_i,
   input wire        tx_busy_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Request taken and its codes
   wire        take = host_word_valid_i && host_ready_o;
   wire [15:0] code = host_word_i[63:48];

   ////////////////////////////////////////
   a_every_answer: assert property (
      take |-> ##[1:8] ans_valid_o)
      else $error("request unanswered");
   a_rts_ack: assert property (
      take && code == 16'hA001 |=> ans_valid_o && ans_word_o[63:48] == 16'h5001)
      else $error("A001 not acknowledged");
   a_ans_hold: assert property (
      !ans_valid_o |-> $stable(ans_word_o))
      else $error("answer word moved");
   a_frame_done: assert property (
      $rose(rx_frame_ready_o) |-> ans_valid_o && ans_word_o[63:40] == 24'h500000)
      else $error("frame done without 5000");
   a_frame_hold: assert property (
      rx_frame_ready_o && !rx_release_i |=> rx_frame_ready_o)
      else $error("frame dropped before release");
   a_busy_refuse: assert property (
      take && host_word_i[63:56] == 8'hB0 && rx_frame_ready_o
      |=> ans_valid_o && ans_word_o[47:40] == 8'hFF)
      else $error("subframe taken when full");
   a_len_range: assert property (
      rx_frame_ready_o |-> rx_len_o != 9'h000 && rx_len_o <= 9'h100)
      else $error("frame length out of range");
   a_start_first: assert property (
      $rose(tx_busy_o) |-> $past(tx_start_i))
      else $error("send began without start");
   a_send_busy: assert property (
      ans_valid_o && ans_word_o[63:56] == 8'hB0 |-> tx_busy_o)
      else $error("data outside a send");
   a_seq_nonzero: assert property (
      ans_valid_o && ans_word_o[63:56] == 8'hB0 |-> ans_word_o[55:48] != 8'h00)
      else $error("subframe number zero");

   // Main scenarios reached
   c_rts: cover property (take && code == 16'hA001);
   c_frame: cover property ($rose(rx_frame_ready_o));
   c_sent: cover property ($fell(tx_busy_o));
   c_refuse: cover property (take && rx_frame_ready_o);
endmodule // frame_xfer_asserts

bind frame_xfer frame_xfer_asserts i_frame_xfer_asserts (
   .core_clk_i       (core_clk_i),
   .rst_n_i          (rst_n_i),
   .host_word_valid_i(host_word_valid_i),
   .host_word_i      (host_word_i),
   .host_ready_o     (host_ready_o),
   .ans_valid_o      (ans_valid_o),
   .ans_word_o       (ans_word_o),
   .rx_frame_ready_o (rx_frame_ready_o),
   .rx_len_o         (rx_len_o),
   .rx_release_i     (rx_release_i),
   .tx_start_i       (tx_start_i),
   .tx_busy_o        (tx_busy_o)
);

// ---- sim/host_model.sv ----
/*
   Host CPU model issuing 8-byte request words.
   Assumes valid/ready take and a one-cycle answer pulse.
*/
`timescale 1ns/1ps

module host_model (
   input  wire        clk_i,
   input  wire        ready_i,
   input  wire        ans_valid_i,
   input  wire [63:0] ans_word_i,
   output reg         valid_o = 1'b0,
   output reg  [63:0] word_o = 64'h0
);
   // One request outstanding; answer awaited
   task xfer(input [63:0] w, input integer slow, output [63:0] a,
             output logic ok);
      integer i;
      reg     t;
      begin
         t  = 1'b0;
         ok = 1'b0;
         repeat (slow + 1) @(posedge clk_i);
         valid_o <= 1'b1;
         word_o  <= w;
         for (i = 0; i < 20 && !t; i = i + 1) begin
            @(posedge clk_i);
            t = ready_i;
         end
         valid_o <= 1'b0;
         word_o  <= ~w; // Released word inverted
         for (i = 0; i < 20 && !ok; i = i + 1) begin
            @(posedge clk_i);
            ok = ans_valid_i;
         end
         a  = ans_word_i;
         ok = ok & t;
      end
   endtask
endmodule // host_model

// ---- sim/tb_top.sv ----
/*
   Self-checking bench for frame_xfer through host_model.
   Assumes design, checker and host model compiled with it.
*/
`timescale 1ns/1ps

module tb_top;
   localparam [63:0] ALL = 64'hFFFFFFFFFFFFFFFF;
   localparam [63:0] M24 = 64'hFFFFFF0000000000;
   reg         clk, rst_n, rx_rel, tx_valid, tx_start;
   reg  [7:0]  rx_addr, tx_byte;
   wire        h_valid, h_ready, a_valid, rx_ready, tx_rdy, tx_busy;
   wire [63:0] h_word, a_word;
   wire [8:0]  rx_len;
   wire [7:0]  rx_data;
   integer     n_errors;
   integer     tests_run;
   integer     i, acc, n1;
   reg  [7:0]  pay [0:257];
   reg  [7:0]  txq [$];

   frame_xfer i_frame_xfer (
      .core_clk_i       (clk),
      .rst_n_i          (rst_n),
      .host_word_valid_i(h_valid),
      .host_word_i      (h_word),
      .host_ready_o     (h_ready),
      .ans_valid_o      (a_valid),
      .ans_word_o       (a_word),
      .rx_frame_ready_o (rx_ready),
      .rx_len_o         (rx_len),
      .rx_rd_addr_i     (rx_addr),
      .rx_rd_data_o     (rx_data),
      .rx_release_i     (rx_rel),
      .tx_byte_i        (tx_byte),
      .tx_valid_i       (tx_valid),
      .tx_ready_o       (tx_rdy),
      .tx_start_i       (tx_start),
      .tx_busy_o        (tx_busy)
   );
   host_model i_host_model (
      .clk_i      (clk),
      .ready_i    (h_ready),
      .ans_valid_i(a_valid),
      .ans_word_i (a_word),
      .valid_o    (h_valid),
      .word_o     (h_word)
   );

   // 200 MHz clock
   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   ////////////////////////////////////////
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, n_errors);
         if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   task hang;
      begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED %0t no handshake", $time);
         stop_test;
      end
   endtask

   task chk(input [63:0] got, input [63:0] exp, input [63:0] m = ALL);
      begin
         tests_run = tests_run + 1;
         if ((got & m) !== (exp & m)) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
         end
      end
   endtask

   // One request, answer compared
   task req(input [63:0] w, input [63:0] e, input [63:0] m = ALL);
      reg [63:0] a;
      reg        ok;
      begin
         i_host_model.xfer(w, $urandom % 3, a, ok);
         if (ok !== 1'b1)
            hang;
         chk(a, e, m);
      end
   endtask

   // Host sends a frame; program reads and releases it
   task rx_frame(input integer len, input bad);
      integer    k, j, n;
      reg [63:0] w;
      begin
         n = (len + 5) / 6;
         for (k = 0; k < 258; k = k + 1)
            pay[k] = 8'($urandom);
         req({16'hA001, len[15:0], 32'h0}, 64'h5001000000000000);
         for (k = 1; k <= n; k = k + 1) begin
            if (bad && k == 1)
               req({16'hB002, 48'h0}, 64'h5001FF0000000000, M24);
            w = {8'hB0, k[7:0], 48'h0};
            for (j = 0; j < 6; j = j + 1)
               w[47 - 8 * j -: 8] = pay[6 * k - 6 + j];
            req(w, {8'h50, (k == n) ? 8'h00 : 8'h01, 8'h00, k[7:0],
                32'h0});
         end
         chk({63'h0, rx_ready}, 64'h1);
         chk({55'h0, rx_len}, len);
         for (k = 0; k < len; k = k + 1) begin
            @(posedge clk);
            rx_addr <= k[7:0];
            @(posedge clk);
            @(posedge clk);
            #1 chk({56'h0, rx_data}, {56'h0, pay[k]});
         end
         req({16'hA001, 16'h0006, 32'h0}, 64'h5001FF0000000000, M24);
         req({16'hB001, 48'h0}, 64'h5001FF0000000000, M24);
         @(posedge clk);
         rx_rel <= 1'b1;
         @(posedge clk);
         rx_rel <= 1'b0;
         @(posedge clk);
         #1 chk({63'h0, rx_ready}, 64'h0);
         $display("receive of %0d bytes done", len);
      end
   endtask

   // Program offers bytes, counting those taken
   task tx_put(input integer want, input integer cyc);
      integer k;
      begin
         acc = 0;
         @(posedge clk);
         tx_valid <= 1'b1;
         tx_byte  <= 8'($urandom);
         for (k = 0; k < cyc && acc < want; k = k + 1) begin
            @(posedge clk);
            if (tx_rdy === 1'b1) begin
               txq.push_back(tx_byte);
               acc = acc + 1;
               tx_byte <= 8'($urandom);
            end
         end
         tx_valid <= 1'b0;
      end
   endtask

   task start_send;
      begin
         repeat (40) @(posedge clk);
         tx_start <= 1'b1;
         @(posedge clk);
         tx_start <= 1'b0;
         #1 chk({63'h0, tx_busy}, 64'h1);
      end
   endtask

   // Host collects a started frame of n bytes
   task tx_frame(input integer n, input bad);
      integer    k, j;
      reg [63:0] w;
      begin
         for (k = 1; k <= (n + 5) / 6; k = k + 1) begin
            w = {8'hB0, k[7:0], 48'h0};
            for (j = 0; j < 6; j = j + 1)
               if (6 * k - 6 + j < n)
                  w[47 - 8 * j -: 8] = txq[6 * k - 6 + j];
            if (bad && k == 2)
               req({16'hC009, 48'h0}, 64'h5000FF0000000000, M24);
            req((k == 1) ? {16'hA080, 48'h0} : {8'hC0, k[7:0] - 8'h01,
                48'h0}, w);
         end
         req({8'hC0, k[7:0] - 8'h01, 48'h0},
             {24'h500000, k[7:0] - 8'h01, 32'h0});
         @(posedge clk);
         #1 chk({63'h0, tx_busy}, 64'h0);
         for (j = 0; j < n; j = j + 1)
            void'(txq.pop_front());
         $display("send of %0d bytes done", n);
      end
   endtask

   ////////////////////////////////////////
   initial begin
      n_errors  = 0;
      tests_run = 0;
      rst_n     = 1'b0;
      rx_addr   = 8'h00;
      rx_rel    = 1'b0;
      tx_byte   = 8'h00;
      tx_valid  = 1'b0;
      tx_start  = 1'b0;
      void'($urandom(32'h9E52));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 20 && h_ready !== 1'b1; i = i + 1)
         @(posedge clk);
      if (h_ready !== 1'b1)
         hang;
      req({16'hA080, 48'h0}, 64'h5000FF0000000000, M24);
      req({16'h7700, 48'h0}, 64'h5000FF0000000000, M24);
      req({16'hB001, 48'h0}, 64'h5001FF0000000000, M24);
      req({16'hA001, 48'h0}, 64'h5001FF0000000000, M24);
      req({16'hA001, 16'h0101, 32'h0}, 64'h5001FF0000000000, M24);
      rx_frame(6, 1'b0);
      rx_frame(7, 1'b1);
      rx_frame(256, 1'b0);
      rx_frame(1 + $urandom % 255, 1'b0);
      n1 = 7 + $urandom % 14;
      tx_put(n1, 100);
      start_send;
      tx_put(99, 30);
      chk(acc, 64'd16);
      tx_frame(n1, 1'b1);
      start_send;
      tx_frame(16, 1'b0);
      stop_test;
   end
endmodule // tb_top
